// ---- verilog/memory_space_pkg.sv ----
// Constants shared by the memory space select decoder and its select array.
package memory_space_pkg;
    localparam int ARRAY_INPUTS   = 73;
    localparam int NUM_SELECTS    = 20;
    localparam int TERMS_PER_SEL  = 3;
    localparam int NUM_TERMS      = NUM_SELECTS * TERMS_PER_SEL;

    typedef logic [ARRAY_INPUTS-1:0] term_t;

    // Field positions on the shared array input bus.
    localparam int BUS_ADDR_LSB   = 0;
    localparam int BUS_CTRL_LSB   = 16;
    localparam int BUS_RESET      = 19;
    localparam int BUS_PDN        = 20;
    localparam int BUS_PA_LSB     = 21;
    localparam int BUS_PB_LSB     = 29;
    localparam int BUS_PC_LSB     = 37;
    localparam int BUS_PD_LSB     = 45;
    localparam int BUS_PAGE_LSB   = 48;
    localparam int BUS_FB1_LSB    = 56;
    localparam int BUS_FB2_LSB    = 64;
    localparam int BUS_READY      = 72;

    // Select indices on the select array output.
    localparam int SEL_PRIMARY    = 0;
    localparam int SEL_SECONDARY  = 8;
    localparam int SEL_SRAM       = 12;
    localparam int SEL_CONFIG     = 13;
    localparam int SEL_DEBUG      = 14;
    localparam int SEL_PERIPH     = 15;
    localparam int SEL_EXTERNAL   = 17;

    // Control strobe order on the bus and in the strobe registers.
    localparam int STB_WRITE      = 0;
    localparam int STB_READ       = 1;
    localparam int STB_FETCH      = 2;

    // Memory space map fields.
    localparam int MAP_SRAM_CODE  = 0;
    localparam int MAP_SEC_CODE   = 1;
    localparam int MAP_PRI_CODE   = 2;
    localparam int MAP_SEC_DATA   = 3;
    localparam int MAP_PRI_DATA   = 4;
    localparam int MAP_PIO        = 7;
    localparam logic [7:0] MAP_USED_MASK = 8'h9f;
    localparam logic [7:0] MAP_RESET     = 8'h0c;
    localparam logic [7:0] PAGE_RESET    = 8'h00;

    // Offsets inside the configuration register window.
    localparam logic [7:0] PAGE_OFFSET   = 8'he0;
    localparam logic [7:0] MAP_OFFSET    = 8'h02;

    // Standby entry after the inputs stay still.
    localparam int CLK_PERIOD_NS   = 10;
    localparam int STANDBY_TIME_NS = 70;
    localparam int STANDBY_CYCLES  = (STANDBY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Default programmed equation: configuration window at address 16'hb0xx.
    localparam int    CONFIG_TERM  = SEL_CONFIG * TERMS_PER_SEL;
    localparam term_t CONFIG_CARE  = term_t'(16'hff00);
    localparam term_t CONFIG_MATCH = term_t'(16'hb000);
    localparam logic [NUM_TERMS-1:0] DEFAULT_USED = NUM_TERMS'(1) << CONFIG_TERM;
endpackage

// ---- verilog/select_array.sv ----
// Sum-of-products select array evaluated over the shared input bus.
module select_array #(
    parameter logic [memory_space_pkg::NUM_TERMS-1:0] TERM_USED = memory_space_pkg::DEFAULT_USED,
    parameter memory_space_pkg::term_t TERM_CARE  [memory_space_pkg::NUM_TERMS] = '{default: '0},
    parameter memory_space_pkg::term_t TERM_MATCH [memory_space_pkg::NUM_TERMS] = '{default: '0}
) (
    input  wire memory_space_pkg::term_t          array_inputs,
    output logic [memory_space_pkg::NUM_SELECTS-1:0] selects
);
    import memory_space_pkg::*;

    logic [NUM_TERMS-1:0] hits;

    function automatic logic term_hit(term_t in, term_t care, term_t match);
        return ((in ^ match) & care) == '0;
    endfunction

    genvar t;
    generate
        for (t = 0; t < NUM_TERMS; t++) begin : g_term
            assign hits[t] = TERM_USED[t] && term_hit(array_inputs, TERM_CARE[t], TERM_MATCH[t]);
        end
        for (t = 0; t < NUM_SELECTS; t++) begin : g_sel
            assign selects[t] = |hits[t*TERMS_PER_SEL +: TERMS_PER_SEL];
        end
    endgenerate
endmodule

// ---- verilog/memory_space_decode.sv ----
// Memory space select decoder with page register and space map.
module memory_space_decode #(
    parameter logic [memory_space_pkg::NUM_TERMS-1:0] TERM_USED = memory_space_pkg::DEFAULT_USED,
    parameter memory_space_pkg::term_t TERM_CARE  [memory_space_pkg::NUM_TERMS] =
        '{memory_space_pkg::CONFIG_TERM: memory_space_pkg::CONFIG_CARE, default: '0},
    parameter memory_space_pkg::term_t TERM_MATCH [memory_space_pkg::NUM_TERMS] =
        '{memory_space_pkg::CONFIG_TERM: memory_space_pkg::CONFIG_MATCH, default: '0},
    parameter logic [7:0] MAP_INIT = memory_space_pkg::MAP_RESET
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [19:0] address,
    input  wire logic        program_fetch_strobe_n,
    input  wire logic        read_strobe_n,
    input  wire logic        write_strobe_n,
    input  wire logic [7:0]  data_in,
    output logic [7:0]       data_out,
    output logic             data_out_enable,
    input  wire logic        wide_address_mode,
    input  wire logic        fast_response,
    input  wire logic [4:0]  control_block,
    input  wire logic        power_down_input,
    input  wire logic [7:0]  port_a_cells,
    input  wire logic [7:0]  port_b_cells,
    input  wire logic [7:0]  port_c_cells,
    input  wire logic [2:0]  port_d_inputs,
    input  wire logic [7:0]  cell_group_one_feedback,
    input  wire logic [7:0]  cell_group_two_feedback,
    input  wire logic        secondary_ready,
    output logic [7:0]       primary_sector_enables,
    output logic [3:0]       secondary_sector_enables,
    output logic             sram_enable,
    output logic             config_register_window_enable,
    output logic             debug_port_enable,
    output logic [1:0]       peripheral_enables,
    output logic [2:0]       external_chip_selects,
    output logic [7:0]       page_bits,
    output logic [7:0]       memory_space_map,
    output logic             array_standby
);
    import memory_space_pkg::*;

    term_t                  bus_d;
    term_t                  bus_q;
    logic [2:0]             strobe_d;
    logic [2:0]             strobe_q;
    logic [2:0]             out_strobe_q;
    logic [7:0]             data_q;
    logic [7:0]             offset_q;
    logic [7:0]             page_q;
    logic [7:0]             map_q;
    logic [NUM_SELECTS-1:0] sel_eval;
    logic [NUM_SELECTS-1:0] sel_q;
    logic [3:0]             still_cnt_q;
    logic                   wake_q;
    logic                   bus_changed;
    logic                   cfg_read;
    logic                   cfg_write;
    logic                   fetch;
    logic                   rd;
    logic                   wr;
    logic                   io_hit;
    logic [3:0]             sec_hit;

    assign strobe_d = {~program_fetch_strobe_n, ~read_strobe_n, ~write_strobe_n};

    // Assemble the shared input bus of the select array.
    always_comb begin
        bus_d = '0;
        bus_d[BUS_ADDR_LSB +: 16] = wide_address_mode ? address[19:4] : address[15:0];
        bus_d[BUS_CTRL_LSB +: 3]  = strobe_d & ~control_block[2:0];
        bus_d[BUS_RESET]          = reset & ~control_block[3];
        bus_d[BUS_PDN]            = power_down_input & ~control_block[4];
        bus_d[BUS_PA_LSB +: 8]    = port_a_cells;
        bus_d[BUS_PB_LSB +: 8]    = port_b_cells;
        bus_d[BUS_PC_LSB +: 8]    = port_c_cells;
        bus_d[BUS_PD_LSB +: 3]    = port_d_inputs;
        bus_d[BUS_PAGE_LSB +: 8]  = page_q;
        bus_d[BUS_FB1_LSB +: 8]   = cell_group_one_feedback;
        bus_d[BUS_FB2_LSB +: 8]   = cell_group_two_feedback;
        bus_d[BUS_READY]          = secondary_ready;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bus_q    <= '0;
            strobe_q <= '0;
            data_q   <= '0;
            offset_q <= '0;
        end else begin
            bus_q    <= bus_d;
            strobe_q <= strobe_d;
            data_q   <= data_in;
            offset_q <= address[7:0];
        end
    end

    // The equations are parameters, so they hold from the first cycle on.
    select_array #(
        .TERM_USED  (TERM_USED),
        .TERM_CARE  (TERM_CARE),
        .TERM_MATCH (TERM_MATCH)
    ) u_select_array (
        .array_inputs (bus_q),
        .selects      (sel_eval)
    );

    // Standby: count cycles with a still bus; the first change after standby costs a cycle.
    assign bus_changed = bus_d != bus_q;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            still_cnt_q   <= '0;
            array_standby <= 1'b0;
            wake_q        <= 1'b0;
        end else begin
            if (bus_changed) begin
                still_cnt_q <= '0;
            end else if (still_cnt_q != 4'(STANDBY_CYCLES)) begin
                still_cnt_q <= still_cnt_q + 4'd1;
            end
            array_standby <= !fast_response && !bus_changed
                             && still_cnt_q >= 4'(STANDBY_CYCLES - 1);
            wake_q        <= array_standby && bus_changed;
        end
    end

    // Configuration window registers.
    assign cfg_read  = sel_eval[SEL_CONFIG] && strobe_q[STB_READ];
    assign cfg_write = sel_eval[SEL_CONFIG] && strobe_q[STB_WRITE];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            page_q <= PAGE_RESET;
        end else if (cfg_write && offset_q == PAGE_OFFSET) begin
            page_q <= data_q;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            map_q <= MAP_INIT;
        end else if (cfg_write && offset_q == MAP_OFFSET) begin
            map_q <= data_q & MAP_USED_MASK;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            data_out        <= '0;
            data_out_enable <= 1'b0;
        end else begin
            data_out_enable <= cfg_read && (offset_q == PAGE_OFFSET || offset_q == MAP_OFFSET);
            if (cfg_read && offset_q == PAGE_OFFSET) begin
                data_out <= page_q;
            end else if (cfg_read && offset_q == MAP_OFFSET) begin
                data_out <= map_q;
            end else begin
                data_out <= '0;
            end
        end
    end

    // Space qualification and priority among overlapping selects.
    assign fetch  = strobe_q[STB_FETCH];
    assign rd     = strobe_q[STB_READ];
    assign wr     = strobe_q[STB_WRITE];
    assign io_hit = sel_eval[SEL_CONFIG] || (map_q[MAP_PIO] && |sel_eval[SEL_PERIPH +: 2]);
    assign sec_hit = sel_eval[SEL_SECONDARY +: 4]
                     & {4{(fetch && map_q[MAP_SEC_CODE]) || (rd && map_q[MAP_SEC_DATA]) || wr}};

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sel_q                         <= '0;
            out_strobe_q                  <= '0;
            primary_sector_enables        <= '0;
            secondary_sector_enables      <= '0;
            sram_enable                   <= 1'b0;
            config_register_window_enable <= 1'b0;
            debug_port_enable             <= 1'b0;
            peripheral_enables            <= '0;
            external_chip_selects         <= '0;
        end else if (!wake_q) begin
            sel_q                    <= sel_eval;
            out_strobe_q             <= strobe_q;
            sram_enable              <= sel_eval[SEL_SRAM]
                                        && (rd || wr || (fetch && map_q[MAP_SRAM_CODE]));
            secondary_sector_enables <= (sel_eval[SEL_SRAM] || io_hit) ? 4'd0 : sec_hit;
            // Primary needs both code and data bits set to serve both spaces.
            primary_sector_enables   <= (sel_eval[SEL_SRAM] || io_hit || |sec_hit) ? 8'd0 :
                sel_eval[SEL_PRIMARY +: 8] & {8{(fetch && map_q[MAP_PRI_CODE])
                || (rd && map_q[MAP_PRI_DATA]) || wr}};
            config_register_window_enable <= sel_eval[SEL_CONFIG] && (rd || wr);
            debug_port_enable        <= sel_eval[SEL_DEBUG];
            peripheral_enables       <= sel_eval[SEL_PERIPH +: 2]
                                        & {2{map_q[MAP_PIO] && (rd || wr)}};
            external_chip_selects    <= sel_eval[SEL_EXTERNAL +: 3];
        end
    end

    assign page_bits        = page_q;
    assign memory_space_map = map_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_MAP_APPLIED: assert property (
        cfg_write && offset_q == MAP_OFFSET |=> map_q == ($past(data_q) & MAP_USED_MASK))
        else $error("space map write not applied");
    AST_PAGE_WRITE: assert property (
        cfg_write && offset_q == PAGE_OFFSET |=> page_q == $past(data_q))
        else $error("page write not stored");
    AST_PAGE_READ: assert property (
        cfg_read && offset_q == PAGE_OFFSET |=> data_out_enable && data_out == $past(page_q))
        else $error("page read back wrong");
    AST_PAGE_ON_BUS: assert property (
        ##1 bus_q[BUS_PAGE_LSB +: 8] == $past(page_q))
        else $error("page bits missing from array inputs");
    AST_WIDE_ADDRESS: assert property (
        wide_address_mode |=> bus_q[BUS_ADDR_LSB +: 16] == $past(address[19:4]))
        else $error("wide mode address bits wrong");
    AST_CONTROL_BLOCKED: assert property (
        control_block[STB_FETCH] |=> !bus_q[BUS_CTRL_LSB + STB_FETCH])
        else $error("blocked control signal reached arrays");
    AST_SRAM_NEEDS_SELECT: assert property (
        sram_enable |-> sel_q[SEL_SRAM])
        else $error("sram enabled without its select");
    AST_SRAM_OVER_FLASH: assert property (
        sram_enable |-> primary_sector_enables == '0 && secondary_sector_enables == '0)
        else $error("flash enabled under sram");
    AST_SECONDARY_OVER_PRIMARY: assert property (
        |secondary_sector_enables |-> primary_sector_enables == '0)
        else $error("primary enabled under secondary");
    AST_FETCH_GATED: assert property (
        ##1 (|primary_sector_enables && out_strobe_q == 3'b100) |-> $past(map_q[MAP_PRI_CODE], 1))
        else $error("primary fetched without code access");
    AST_FAST_NO_STANDBY: assert property (
        fast_response |=> !array_standby)
        else $error("standby entered with fast response set");
endmodule

// ---- verif/cpu_model.sv ----
// Processor model that issues register bus cycles to the decoder.
module cpu_model (
    input  wire logic        clk,
    output logic [19:0]      address,
    output logic             program_fetch_strobe_n,
    output logic             read_strobe_n,
    output logic             write_strobe_n,
    output logic [7:0]       data_in,
    input  wire logic [7:0]  data_out,
    input  wire logic        data_out_enable
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        address = 20'h0_0000;
        program_fetch_strobe_n = 1'b1;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        data_in = 8'h00;
    end

    // The request holds until the caller idles the bus.
    task automatic drive(input logic [19:0] a, input logic wr, input logic rd, input logic fe,
                         input logic [7:0] d);
        @(posedge clk);
        address <= a;
        write_strobe_n <= ~wr;
        read_strobe_n <= ~rd;
        program_fetch_strobe_n <= ~fe;
        data_in <= d;
    endtask

    // Released data lines flip so a stale value never looks valid.
    task automatic idle();
        @(posedge clk);
        address <= 20'h0_0000;
        write_strobe_n <= 1'b1;
        read_strobe_n <= 1'b1;
        program_fetch_strobe_n <= 1'b1;
        data_in <= ~data_in;
    endtask

    task automatic write_reg(input logic [19:0] a, input logic [7:0] d);
        drive(a, 1'b1, 1'b0, 1'b0, d);
        idle();
    endtask

    task automatic read_reg(input logic [19:0] a, output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d = 8'h00;
        drive(a, 1'b0, 1'b1, 1'b0, data_in);
        for (int n = 0; n < 6 && !ok; n++) begin
            @(posedge clk);
            #1;
            if (data_out_enable === 1'b1) begin
                ok = 1'b1;
                d = data_out;
            end
        end
        idle();
    endtask
endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the memory space select decoder.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import memory_space_pkg::*;

    localparam logic [19:0] WIN = 20'h0_b000;
    logic        clk, reset, wide_address_mode, fast_response, power_down_input;
    logic        secondary_ready, pf_n, rd_n, wr_n, data_out_enable, sram, cfg, standby, dbg;
    logic [19:0] address;
    logic [7:0]  data_in, data_out, pa, pb, pc, fb1, fb2, primary, page_bits, space_map;
    logic [7:0]  d, rd, pg, mp;
    logic [4:0]  control_block;
    logic [3:0]  secondary;
    logic [2:0]  pd, ecs;
    logic [1:0]  periph;
    logic        ok;
    integer      seed;
    int          n_errors, checked, n;
    logic [7:0]  maps [6] = '{8'h14, 8'hff, 8'h60, 8'h0c, 8'h00, 8'h9f};
    logic [20:0] probes [6] = '{21'h0_b055, 21'h0_a055, 21'h1_b000_0, 21'h1_4b00_0,
                                21'h0_0b00_0, 21'h1_b0e0_0};
    logic [15:0] spots [7] = '{16'h0055, 16'h1055, 16'h3055, 16'h8055,
                               16'hc055, 16'hd055, 16'he055};

    // Bench equations, term index = select * 3: primary sector 0 at 0x0000-0x3fff,
    // secondary sector 0 at 0x0000-0x1fff, SRAM at 0x0000-0x07ff, window at 0xb0xx,
    // debug port at 0xd0xx, peripheral 0 at 0xc0xx, external select 0 at 0xe0xx.
    localparam term_t AHI = term_t'(16'hff00);
    localparam term_t CARE [NUM_TERMS] = '{0: term_t'(16'hc000), 24: term_t'(16'he000),
        36: term_t'(16'hf800), 39: CONFIG_CARE, 42: AHI, 45: AHI, 51: AHI, default: '0};
    localparam term_t MATCH [NUM_TERMS] = '{39: CONFIG_MATCH, 42: term_t'(16'hd000),
        45: term_t'(16'hc000), 51: term_t'(16'he000), default: '0};
    localparam logic [NUM_TERMS-1:0] USED = 60'h8_2490_0100_0001;

    cpu_model i_cpu (.clk(clk), .address(address), .program_fetch_strobe_n(pf_n),
        .read_strobe_n(rd_n), .write_strobe_n(wr_n), .data_in(data_in),
        .data_out(data_out), .data_out_enable(data_out_enable));

    memory_space_decode #(.TERM_USED(USED), .TERM_CARE(CARE), .TERM_MATCH(MATCH)) i_dut (
        .clk(clk), .reset(reset), .address(address),
        .program_fetch_strobe_n(pf_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
        .data_in(data_in), .data_out(data_out), .data_out_enable(data_out_enable),
        .wide_address_mode(wide_address_mode), .fast_response(fast_response),
        .control_block(control_block), .power_down_input(power_down_input),
        .port_a_cells(pa), .port_b_cells(pb), .port_c_cells(pc), .port_d_inputs(pd),
        .cell_group_one_feedback(fb1), .cell_group_two_feedback(fb2),
        .secondary_ready(secondary_ready), .primary_sector_enables(primary),
        .secondary_sector_enables(secondary), .sram_enable(sram),
        .config_register_window_enable(cfg), .debug_port_enable(dbg),
        .peripheral_enables(periph), .external_chip_selects(ecs), .page_bits(page_bits),
        .memory_space_map(space_map), .array_standby(standby));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Expected selects for the bench equations under space map m and the priority rules.
    function automatic logic [7:0] expect_sel(input logic [15:0] b, input logic fe,
                                              input logic [7:0] m);
        logic s, io, sq, pq, rw;
        rw = !fe;
        s  = b[15:11] == 5'h00;
        io = b[15:8] == 8'hb0 || (b[15:8] == 8'hc0 && m[MAP_PIO]);
        sq = b[15:13] == 3'h0 && (fe ? m[MAP_SEC_CODE] : m[MAP_SEC_DATA]);
        pq = b[15:14] == 2'h0 && (fe ? m[MAP_PRI_CODE] : m[MAP_PRI_DATA]);
        return {pq && !s && !io && !sq, sq && !s && !io, s && (rw || m[MAP_SRAM_CODE]),
                b[15:8] == 8'hb0 && rw, b[15:8] == 8'hd0, io && b[15:8] == 8'hc0 && rw,
                b[15:8] == 8'he0, 1'b0};
    endfunction

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Array inputs and blocking bits change at random; the selects must not depend on them.
    task automatic stir();
        @(posedge clk);
        {pa, pb, pc, fb1} <= $random(seed);
        {fb2, pd, secondary_ready, power_down_input} <= 13'($random(seed));
        control_block <= 5'($random(seed));
    endtask

    task automatic probe(input logic [19:0] a, input logic wide, input logic fe);
        logic [7:0] e;
        logic [7:0] o;
        e = expect_sel(wide ? a[19:4] : a[15:0], fe, mp);
        o = {2'b00, e[3], 1'b0, e[2], 2'b00, e[1]};
        @(posedge clk);
        wide_address_mode <= wide;
        i_cpu.drive(a, 1'b0, !fe, fe, 8'h00);
        repeat (4) @(posedge clk);
        #1;
        check("primary_sector", {7'h00, e[7]}, primary);
        check("secondary_sector", {7'h00, e[6]}, {4'h0, secondary});
        check("sram_select", {7'h00, e[5]}, {7'h00, sram});
        check("window_select", {7'h00, e[4]}, {7'h00, cfg});
        check("other_selects", o, {2'b00, dbg, periph, ecs});
        check("standby_busy", 8'h00, {7'h00, standby});
        i_cpu.idle();
    endtask

    initial begin
        #500000;
        n_errors++;
        end_of_test();
    end

    initial begin
        seed = 95;
        n_errors = 0;
        checked = 0;
        {reset, fast_response, wide_address_mode, control_block} = 8'hc0;
        {pa, pb, pc, pd, fb1, fb2, secondary_ready, power_down_input} = '0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        check("map_reset", MAP_RESET, space_map);
        check("page_reset", PAGE_RESET, page_bits);
        for (int i = 0; i < 8; i++) begin
            d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
            stir();
            i_cpu.write_reg(WIN | PAGE_OFFSET, d);
            i_cpu.read_reg(WIN | PAGE_OFFSET, rd, ok);
            check("page_read_ok", 8'h01, {7'h00, ok});
            check("page_read", d, rd);
            check("page_bits", d, page_bits);
            pg = d;
        end
        for (int i = 0; i < 8; i++) begin
            d = (i < 6) ? maps[i] : 8'($random(seed));
            i_cpu.write_reg(WIN | MAP_OFFSET, d);
            @(posedge clk);
            #1;
            check("map_out", d & MAP_USED_MASK, space_map);
            i_cpu.read_reg(WIN | MAP_OFFSET, rd, ok);
            check("map_read", d & MAP_USED_MASK, rd);
            check("map_read_ok", 8'h01, {7'h00, ok});
            mp = d & MAP_USED_MASK;
            for (int k = 0; k < 14; k++) begin
                probe({4'h0, spots[k / 2]}, 1'b0, k[0]);
            end
        end
        i_cpu.write_reg(WIN | 20'h0_00e1, ~pg);
        i_cpu.write_reg(20'h0_a0e0, ~pg);
        i_cpu.read_reg(WIN | 20'h0_00e1, rd, ok);
        check("bad_offset_read", 8'h00, {7'h00, ok});
        check("page_kept", pg, page_bits);
        for (int i = 0; i < 6; i++) begin
            probe(probes[i][19:0], probes[i][20], 1'b0);
        end
        @(posedge clk);
        fast_response <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check("standby_early", 8'h00, {7'h00, standby});
        for (n = 0; n < 20 && standby !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        check("standby_set", 8'h01, {7'h00, standby});
        probe(WIN | 20'h0_0055, 1'b0, 1'b0);
        @(posedge clk);
        fast_response <= 1'b1;
        repeat (20) @(posedge clk);
        #1;
        check("standby_fast", 8'h00, {7'h00, standby});
        end_of_test();
    end
endmodule
